/* rtl/sfcf_front_end.sv */
// command front end of a serial flash: opcode decode and phase sequencing
// assumes the array core sits on i_ref_clk and a host drives i_sclk/i_cs_n
// Overview of operation
// RULE_01 - accept clock idling high or low
// RULE_02 - four-line mode moves opcode, address, data quad
// RULE_03 - opcode 35h enters four-line mode
// RULE_04 - opcode F5h returns to single-line mode
// RULE_05 - host waits deselect gap after mode switch
// RULE_06 - 02h plus address programs page
// RULE_07 - erase opcodes: sector, half, block, chip
// RULE_08 - address byte clocks follow line count
// RULE_09 - fast read dummy eight or four
// RULE_10 - decode remaining read opcodes per mode
// RULE_11 - 38h quad page program single mode
// RULE_12 - sample rising edge, drive falling edge
// RULE_13 - unknown opcode: ignore, outputs off
// RULE_14 - byte boundary deselect else reject
// RULE_15 - array access ignored while busy
`timescale 1ns/10ps
module sfcf_front_end (
    input  wire logic                      i_ref_clk,  // core clock
    input  wire logic                      i_arst_n,   // async reset
    input  wire logic                      i_ce,       // core clock enable
    input  wire logic                      i_sclk,     // serial link clock
    input  wire logic                      i_cs_n,     // chip select pin
    input  wire logic [3:0]                i_io_in,    // data pins in
    output      logic [3:0]                o_io_out,   // data pins out
    output      logic [3:0]                o_io_oe,    // data pin enables
    output      logic [23:0]               o_rd_addr,  // link-side read address
    input  wire logic [7:0]                i_rd_byte,  // array byte at o_rd_addr
    input  wire logic                      i_busy,     // program or erase running
    output      logic                      o_quad_mode,// four_line_cmd_mode
    output      logic                      o_cmd_valid,// command pulse
    output      sfcf_pkg::sfcf_kind_e      o_cmd_kind, // command class
    output      logic [7:0]                o_cmd_op,   // command opcode
    output      logic [23:0]               o_cmd_addr, // command address
    output      logic [8:0]                o_cmd_len,  // program byte count
    input  wire logic [7:0]                i_pg_idx,   // page buffer index
    output      logic [7:0]                o_pg_data   // page buffer byte
);
    import sfcf_pkg::*;

    // ---------------- link domain ----------------
    logic        link_rst_n;      // reset while deselected
    logic        started_r;       // first clock of frame seen
    logic        fr_tog_r;        // toggles once per frame
    logic        qm_r;            // mode latched for the frame
    sfcf_state_e state_r;         // sequencer state
    logic [4:0]  cnt_r;           // clocks within phase
    logic [31:0] sh_r;            // input shifter
    sfcf_dec_s   cmd_r;           // decoded command
    logic [7:0]  op_r;            // opcode of frame
    logic [23:0] addr_r;          // captured address
    logic [7:0]  pidx_r;          // page write index
    logic [8:0]  nb_r;            // program bytes taken
    logic [7:0]  pg_mem [PAGE_SIZE]; // page buffer
    logic        busy_s;          // busy seen on link clock
    // effective values on the first clock of a frame
    sfcf_state_e st;
    logic [4:0]  ct;
    logic        qm;
    logic [2:0]  w;               // lines this clock
    logic [4:0]  plen;            // clocks in phase
    logic        last;            // final clock of phase
    logic [31:0] sh_nxt;          // shifter after this clock
    sfcf_dec_s   dec;             // decode of incoming opcode

    // chip select high clears the frame logic
    assign link_rst_n = i_arst_n & ~i_cs_n;

    sfcf_sync_if #(.W(1)) busy_if ();
    assign busy_if.d = i_busy;
    // busy level crossing onto the link clock
    sfcf_sync #(.RST_VAL(1'b0)) u_busy_sync (
        .i_clk   (i_sclk),
        .i_rst_n (i_arst_n),
        .s       (busy_if)
    );
    assign busy_s = busy_if.q;

    // opcode decode for the active mode
    function automatic sfcf_dec_s decode(input logic [7:0] op, input logic q,
                                         input logic bz);
        sfcf_dec_s d;
        d = '{ok: 1'b1, kind: K_READ, aw: LN1, dum: DUM_NONE, dw: LN1};
        // RULE_10 read opcode table
        case (op)
            OP_READ:   d.ok = ~q;
            // RULE_09 fast read dummy count
            OP_FAST: begin
                d.aw  = q ? LN4 : LN1;
                d.dw  = d.aw;
                d.dum = q ? DUM_FAST_Q : DUM_FAST_S;
            end
            OP_DOUT2: begin
                d.ok = ~q; d.dum = DUM_WIDE; d.dw = LN2;
            end
            OP_QOUT: begin
                d.ok = ~q; d.dum = DUM_WIDE; d.dw = LN4;
            end
            // RULE_08 address lines per read
            OP_DIO2: begin
                d.ok = ~q; d.aw = LN2; d.dum = DUM_DIO2; d.dw = LN2;
            end
            OP_QIO_SW: begin
                d.ok = ~q; d.aw = LN4; d.dum = DUM_QIO_SW; d.dw = LN4;
            end
            OP_QIO: begin
                d.aw = LN4; d.dum = DUM_QIO; d.dw = LN4;
            end
            // RULE_06 page program either mode
            OP_PROG: begin
                d.kind = K_PROG; d.aw = q ? LN4 : LN1; d.dw = d.aw;
            end
            // RULE_11 quad page program
            OP_QPROG: begin
                d.ok = ~q; d.kind = K_PROG; d.aw = LN4; d.dw = LN4;
            end
            // RULE_07 erase with address
            OP_ERS4K, OP_ERS32K, OP_ERS64K: begin
                d.kind = K_ERASE; d.aw = q ? LN4 : LN1;
            end
            OP_CHIP_A, OP_CHIP_B: begin
                d.kind = K_CHIP; d.aw = LN0;
            end
            // RULE_03 entry only in single-line mode
            OP_ENTRY: begin
                d.ok = ~q; d.kind = K_ENTRY; d.aw = LN0;
            end
            // RULE_04 exit only in four-line mode
            OP_EXIT: begin
                d.ok = q; d.kind = K_EXIT; d.aw = LN0;
            end
            default:   d.ok = 1'b0;
        endcase
        // RULE_15 reads refused while busy
        if (d.kind == K_READ && bz) begin
            d.ok = 1'b0;
        end
        return d;
    endfunction : decode

    // per-clock view; the first clock of a frame starts the opcode
    always_comb begin
        st = started_r ? state_r : ST_OPC;
        ct = started_r ? cnt_r : 5'h00;
        qm = started_r ? qm_r : o_quad_mode;
        case (st)
            // RULE_02 opcode lines follow mode
            ST_OPC:   w = qm ? LN4 : LN1;
            ST_ADDR:  w = cmd_r.aw;
            ST_DIN:   w = cmd_r.dw;
            default:  w = LN1;
        endcase
        case (w)
            LN4:     sh_nxt = {sh_r[27:0], i_io_in};
            LN2:     sh_nxt = {sh_r[29:0], i_io_in[1:0]};
            default: sh_nxt = {sh_r[30:0], i_io_in[0]};
        endcase
        case (st)
            ST_OPC:   plen = (w == LN4) ? 5'd2 : 5'd8;
            // RULE_08 clocks per address
            ST_ADDR:  plen = (w == LN4) ? 5'd6 : (w == LN2) ? 5'd12 : 5'd24;
            ST_DUMMY: plen = {1'b0, cmd_r.dum};
            ST_DIN:   plen = (w == LN4) ? 5'd2 : (w == LN2) ? 5'd4 : 5'd8;
            default:  plen = 5'd1;
        endcase
        last = (ct == plen - 5'd1);
        dec  = decode(sh_nxt[7:0], qm, busy_s);
    end

    // frame start mark: cleared while deselected, set by the first clock
    always_ff @(posedge i_sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            started_r <= 1'b0;
        end else begin
            started_r <= 1'b1;
        end
    end

    // mode and frame toggle, held across deselect
    always_ff @(posedge i_sclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            qm_r     <= QM_RESET;
            fr_tog_r <= 1'b0;
        end else if (!started_r && !i_cs_n) begin
            // RULE_01 idle level change while deselected is no frame
            // mode is static while chip select is low
            qm_r     <= o_quad_mode;
            fr_tog_r <= ~fr_tog_r;
        end
    end

    // RULE_12 sample on rising edge
    always_ff @(posedge i_sclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= ST_IGNORE;
            cnt_r   <= 5'h00;
            sh_r    <= 32'h0000_0000;
            cmd_r   <= '0;
            op_r    <= 8'h00;
            addr_r  <= 24'h00_0000;
            pidx_r  <= 8'h00;
            nb_r    <= 9'h000;
        end else if (!i_cs_n) begin
            // RULE_01 idle edges while deselected change nothing
            sh_r  <= sh_nxt;
            cnt_r <= last ? 5'h00 : ct + 5'h01;
            if (!started_r) begin
                state_r <= ST_OPC;
                nb_r    <= 9'h000;
            end
            case (st)
                ST_OPC: if (last) begin
                    op_r  <= sh_nxt[7:0];
                    cmd_r <= dec;
                    // RULE_13 unknown opcode ignored
                    if (!dec.ok) begin
                        state_r <= ST_IGNORE;
                    end else if (dec.aw != LN0) begin
                        state_r <= ST_ADDR;
                    end else begin
                        state_r <= ST_DONE;
                    end
                end
                ST_ADDR: if (last) begin
                    addr_r <= sh_nxt[23:0];
                    pidx_r <= sh_nxt[7:0];
                    if (cmd_r.kind == K_PROG) begin
                        state_r <= ST_DIN;
                    end else if (cmd_r.kind != K_READ) begin
                        state_r <= ST_DONE;
                    end else begin
                        state_r <= (cmd_r.dum == DUM_NONE) ? ST_DOUT : ST_DUMMY;
                    end
                end
                ST_DUMMY: if (last) begin
                    state_r <= ST_DOUT;
                end
                ST_DIN: if (last) begin
                    pidx_r <= pidx_r + 8'h01;
                    if (nb_r != PAGE_FULL) begin
                        nb_r <= nb_r + 9'h001;
                    end
                end
                // RULE_14 clocks past the end reject
                ST_DONE:  state_r <= ST_IGNORE;
                default:  state_r <= st;
            endcase
        end
    end

    // page buffer write, wrapping within the page
    always_ff @(posedge i_sclk) begin
        if (started_r && st == ST_DIN && last) begin
            pg_mem[pidx_r] <= sh_nxt[7:0];
        end
    end

    // ---------------- link output ----------------
    logic [7:0]  osh_r;  // output shifter
    logic [2:0]  oc_r;   // clocks left in byte
    logic        on_r;   // output running
    logic [23:0] rptr_r; // next read address
    logic [7:0]  ov;     // byte bits to place this edge
    logic [3:0]  opins;  // placed pin values
    logic [3:0]  oen;    // placed enables

    assign o_rd_addr = on_r ? rptr_r : addr_r;
    assign ov = (oc_r == 3'h0) ? i_rd_byte : osh_r;

    // place the top bits on the lines in use
    always_comb begin
        case (cmd_r.dw)
            LN4: begin opins = ov[7:4]; oen = 4'hf; end
            LN2: begin opins = {2'b00, ov[7:6]}; oen = 4'h3; end
            default: begin opins = {2'b00, ov[7], 1'b0}; oen = 4'h2; end
        endcase
    end

    // RULE_12 drive on falling edge
    always_ff @(negedge i_sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            osh_r    <= 8'h00;
            oc_r     <= 3'h0;
            on_r     <= 1'b0;
            rptr_r   <= 24'h00_0000;
            o_io_out <= 4'h0;
            o_io_oe  <= 4'h0;
        end else if (started_r && state_r == ST_DOUT) begin
            o_io_out <= opins;
            o_io_oe  <= oen;
            osh_r    <= ov << cmd_r.dw;
            if (oc_r == 3'h0) begin
                oc_r   <= (cmd_r.dw == LN4) ? 3'h1 : (cmd_r.dw == LN2) ? 3'h3 : 3'h7;
                rptr_r <= o_rd_addr + 24'h00_0001;
                on_r   <= 1'b1;
            end else begin
                oc_r <= oc_r - 3'h1;
            end
        end
    end

    // ---------------- core domain ----------------
    logic cs_s;      // chip select on core clock
    logic cs_prev_r; // previous value
    logic cs_rise;   // end of frame
    logic seen_r;    // last frame toggle handled
    logic ok_link;   // frame ended on a byte boundary

    sfcf_sync_if #(.W(1)) cs_if ();
    assign cs_if.d = i_cs_n;
    // chip select crossing onto the core clock
    sfcf_sync #(.RST_VAL(1'b1)) u_cs_sync (
        .i_clk   (i_ref_clk),
        .i_rst_n (i_arst_n),
        .s       (cs_if)
    );
    assign cs_s    = cs_if.q;
    assign cs_rise = cs_s & ~cs_prev_r & i_ce;
    // link state is still while deselected, so reading it here is safe
    // RULE_14 byte boundary check
    assign ok_link = (fr_tog_r != seen_r) &&
                     (state_r == ST_DONE ||
                      (state_r == ST_DIN && cnt_r == 5'h00 && nb_r != 9'h000));

    // frame end detection
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cs_prev_r <= 1'b1;
            seen_r    <= 1'b0;
        end else if (i_ce) begin
            cs_prev_r <= cs_s;
            if (cs_rise) begin
                seen_r <= fr_tog_r;
            end
        end
    end

    // RULE_03 RULE_04 mode switch at frame end
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_quad_mode <= QM_RESET;
        end else if (cs_rise && ok_link) begin
            if (cmd_r.kind == K_ENTRY) begin
                o_quad_mode <= 1'b1;
            end else if (cmd_r.kind == K_EXIT) begin
                o_quad_mode <= 1'b0;
            end
        end
    end

    // RULE_06 RULE_07 RULE_15 issue to the array core
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_cmd_valid <= 1'b0;
            o_cmd_kind  <= K_NONE;
            o_cmd_op    <= 8'h00;
            o_cmd_addr  <= 24'h00_0000;
            o_cmd_len   <= 9'h000;
        end else if (i_ce) begin
            o_cmd_valid <= 1'b0;
            if (cs_rise && ok_link && !i_busy &&
                (cmd_r.kind == K_PROG || cmd_r.kind == K_ERASE ||
                 cmd_r.kind == K_CHIP)) begin
                o_cmd_valid <= 1'b1;
                o_cmd_kind  <= cmd_r.kind;
                o_cmd_op    <= op_r;
                o_cmd_addr  <= addr_r;
                o_cmd_len   <= nb_r;
            end
        end
    end

    // page buffer readout for the array core
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pg_data <= 8'h00;
        end else if (i_ce) begin
            o_pg_data <= pg_mem[i_pg_idx];
        end
    end

    // ---------------- checks ----------------
    sequence s_addr_quad;
        (state_r == ST_ADDR)[*6] ##1 (state_r != ST_ADDR);
    endsequence
    sequence s_dummy_four;
        (state_r == ST_DUMMY)[*4] ##1 (state_r == ST_DOUT);
    endsequence
    property p_addr_quad;
        @(posedge i_sclk) disable iff (!link_rst_n)
        ($rose(state_r == ST_ADDR) && cmd_r.aw == LN4) |-> s_addr_quad;
    endproperty
    a_addr_quad: assert property (p_addr_quad) else $error("quad address not six clocks"); // RULE_08
    property p_dummy_four;
        @(posedge i_sclk) disable iff (!link_rst_n)
        ($rose(state_r == ST_DUMMY) && cmd_r.dum == DUM_FAST_Q) |-> s_dummy_four;
    endproperty
    a_dummy_four: assert property (p_dummy_four) else $error("dummy phase wrong length"); // RULE_09
    property p_ignore_quiet;
        @(posedge i_sclk) disable iff (!link_rst_n)
        (state_r == ST_IGNORE) |-> (o_io_oe == 4'h0);
    endproperty
    a_ignore_quiet: assert property (p_ignore_quiet) else $error("driving after bad opcode"); // RULE_13
    property p_busy_read;
        @(posedge i_sclk) disable iff (!link_rst_n)
        (st == ST_OPC && last && busy_s && dec.kind == K_READ) |=> (state_r == ST_IGNORE);
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("read taken while busy"); // RULE_15
    property p_quad_out;
        @(posedge i_sclk) disable iff (!link_rst_n)
        (state_r == ST_DOUT && on_r && cmd_r.dw == LN4) |-> (o_io_oe == 4'hf);
    endproperty
    a_quad_out: assert property (p_quad_out) else $error("quad output not on four lines"); // RULE_02
    property p_entry;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (cs_rise && ok_link && cmd_r.kind == K_ENTRY) |=> o_quad_mode;
    endproperty
    a_entry: assert property (p_entry) else $error("entry did not set mode"); // RULE_03
    property p_exit;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (cs_rise && ok_link && cmd_r.kind == K_EXIT) |=> !o_quad_mode;
    endproperty
    a_exit: assert property (p_exit) else $error("exit did not clear mode"); // RULE_04
    property p_reject;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (cs_rise && !ok_link) |=> (!o_cmd_valid && $stable(o_quad_mode));
    endproperty
    a_reject: assert property (p_reject) else $error("rejected frame acted"); // RULE_14
    property p_issue;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (cs_rise && ok_link && !i_busy && cmd_r.kind == K_PROG)
            |=> (o_cmd_valid && o_cmd_kind == K_PROG && o_cmd_addr == $past(addr_r));
    endproperty
    a_issue: assert property (p_issue) else $error("program not issued"); // RULE_06
    property p_erase;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (cs_rise && ok_link && !i_busy && cmd_r.kind == K_ERASE)
            |=> (o_cmd_valid && o_cmd_op == $past(op_r));
    endproperty
    a_erase: assert property (p_erase) else $error("erase not issued"); // RULE_07
    property p_mode_edge;
        @(posedge i_sclk) disable iff (!link_rst_n)
        $rose(started_r) |-> (qm_r == $past(o_quad_mode));
    endproperty
    a_mode_edge: assert property (p_mode_edge) else $error("frame mode not latched"); // RULE_01
endmodule : sfcf_front_end

/* common/sfcf_pkg.sv */
// shared constants and types of the serial flash command front end
// assumes a host that drives chip select and the serial clock
package sfcf_pkg;
    // opcodes decoded by the front end
    localparam logic [7:0] OP_READ   = 8'h03; // normal fetch
    localparam logic [7:0] OP_FAST   = 8'h0b; // fast fetch
    localparam logic [7:0] OP_DOUT2  = 8'h3b; // dual_out_fetch
    localparam logic [7:0] OP_DIO2   = 8'hbb; // dual_io_fetch
    localparam logic [7:0] OP_QOUT   = 8'h6b; // quad_out_fetch
    localparam logic [7:0] OP_QIO    = 8'heb; // quad_io_fetch
    localparam logic [7:0] OP_QIO_SW = 8'he7; // quad_io_fetch_short_wait
    localparam logic [7:0] OP_PROG   = 8'h02; // page_program
    localparam logic [7:0] OP_QPROG  = 8'h38; // quad_page_program
    localparam logic [7:0] OP_ERS4K  = 8'h20; // four_k_erase
    localparam logic [7:0] OP_ERS32K = 8'h52; // half_block_erase
    localparam logic [7:0] OP_ERS64K = 8'hd8; // block_erase
    localparam logic [7:0] OP_CHIP_A = 8'h60; // whole array erase
    localparam logic [7:0] OP_CHIP_B = 8'hc7; // whole array erase
    localparam logic [7:0] OP_ENTRY  = 8'h35; // quad_cmd_entry
    localparam logic [7:0] OP_EXIT   = 8'hf5; // quad_cmd_exit
    // data lines per clock
    localparam logic [2:0] LN0 = 3'h0;
    localparam logic [2:0] LN1 = 3'h1;
    localparam logic [2:0] LN2 = 3'h2;
    localparam logic [2:0] LN4 = 3'h4;
    // dummy clock counts
    localparam logic [3:0] DUM_NONE   = 4'h0;
    localparam logic [3:0] DUM_FAST_S = 4'h8;
    localparam logic [3:0] DUM_FAST_Q = 4'h4;
    localparam logic [3:0] DUM_WIDE   = 4'h8;
    localparam logic [3:0] DUM_DIO2   = 4'h4;
    localparam logic [3:0] DUM_QIO    = 4'h6;
    localparam logic [3:0] DUM_QIO_SW = 4'h4;
    // address and page geometry
    localparam int         ADDR_BITS = 24;
    localparam int         PAGE_SIZE = 256;
    localparam logic [8:0] PAGE_FULL = 9'h100;
    // value of the four-line mode after reset
    localparam logic       QM_RESET  = 1'b0;

    // command classes; only prog, erase and chip are handed to the array core
    typedef enum logic [2:0] {
        K_NONE  = 3'h0,
        K_READ  = 3'h1,
        K_PROG  = 3'h2,
        K_ERASE = 3'h3,
        K_CHIP  = 3'h4,
        K_ENTRY = 3'h5,
        K_EXIT  = 3'h6
    } sfcf_kind_e;

    // link-side sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_OPC    = 7'h01,
        ST_ADDR   = 7'h02,
        ST_DUMMY  = 7'h04,
        ST_DIN    = 7'h08,
        ST_DOUT   = 7'h10,
        ST_DONE   = 7'h20,
        ST_IGNORE = 7'h40
    } sfcf_state_e;

    // result of opcode decode
    typedef struct packed {
        logic       ok;
        sfcf_kind_e kind;
        logic [2:0] aw;
        logic [3:0] dum;
        logic [2:0] dw;
    } sfcf_dec_s;
endpackage : sfcf_pkg

/* common/sfcf_sync_if.sv */
// carrier for a level that crosses into a clock domain
// the source side drives d, the synchroniser returns q
`timescale 1ns/10ps
interface sfcf_sync_if #(parameter int W = 1);
    logic [W-1:0] d; // level from the far domain
    logic [W-1:0] q; // level after two flops
    modport src (output d, input q);
    modport syn (input d, output q);
endinterface : sfcf_sync_if

/* rtl/sfcf_sync.sv */
// two flip-flop level synchroniser
// assumes the carried level changes slowly against i_clk
`timescale 1ns/10ps
module sfcf_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    sfcf_sync_if.syn  s
);
    import sfcf_pkg::*;
    logic [$bits(s.d)-1:0] meta_r; // first stage, read only by stage two
    logic [$bits(s.d)-1:0] hold_r; // second stage

    // two stages, reset to a constant
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= {$bits(s.d){RST_VAL}};
            hold_r <= {$bits(s.d){RST_VAL}};
        end else begin
            meta_r <= s.d;
            hold_r <= meta_r;
        end
    end
    assign s.q = hold_r;
endmodule : sfcf_sync

/* tb/sfcf_host.sv */
// host model: drives chip select, link clock and the data pins
// assumes the bench picks the clock idle level between frames
`timescale 1ns/10ps
module sfcf_host (
    output logic       o_sclk,
    output logic       o_cs_n,
    output logic [3:0] o_io,
    input  logic [3:0] i_io
);
    logic [63:0] rx = 64'h0; // pin bits taken at rising edges
    logic cpol = 1'b0; // idle level of the link clock
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_io   = 4'h0;
    end
    task automatic set_pol(input logic p);
        cpol   = p;
        o_sclk = p;
    endtask : set_pol
    // data set low, taken at rise
    task automatic frame(input logic [63:0] v, input int nb, input int w);
        #7.5 o_cs_n = 1'b0;
        for (int i = nb; i > 0; i -= w) begin
            o_sclk = 1'b0;
            o_io   = (w == 4) ? v[i-1 -: 4] : {3'h0, v[i-1]};
            #7.5 o_sclk = 1'b1;
            rx = (w == 4) ? {rx[59:0], i_io} : {rx[62:0], i_io[1]};
            #7.5;
        end
        o_sclk = cpol;
        o_cs_n = 1'b1;
        // released lines no longer hold the last value
        o_io   = ~o_io;
        #200;
    endtask : frame
endmodule : sfcf_host

/* tb/sfcf_front_end_tb.sv */
// bench of the command front end: frames in, issued commands checked
// assumes the host model above and a 50 MHz core clock
`timescale 1ns/10ps
module sfcf_front_end_tb;
    import sfcf_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, busy = 1'b0, qm, cv, sclk, cs_n;
    logic [3:0] io, io_w, io_out, io_oe;
    logic [23:0] rd_addr, c_addr;
    logic [7:0] c_op, pg_data, pg_idx = 8'h00;
    logic [8:0] c_len;
    sfcf_kind_e c_kind;
    int mismatches = 0, n_compared = 0, n_cmd = 0;
    always #10 clk = ~clk;
    always @(posedge clk) if (cv === 1'b1) n_cmd <= n_cmd + 1;
    assign io_w = (io_oe & io_out) | (~io_oe & io);
    sfcf_host i_sfcf_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(io), .i_io(io_w));
    sfcf_front_end i_sfcf_front_end (.i_ref_clk(clk), .i_arst_n(arst_n), .i_ce(1'b1),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_io_in(io_w), .o_io_out(io_out), .o_io_oe(io_oe),
        .o_rd_addr(rd_addr), .i_rd_byte(rd_addr[7:0] ^ 8'h5a), .i_busy(busy),
        .o_quad_mode(qm), .o_cmd_valid(cv), .o_cmd_kind(c_kind), .o_cmd_op(c_op),
        .o_cmd_addr(c_addr), .o_cmd_len(c_len), .i_pg_idx(pg_idx), .o_pg_data(pg_data));
    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // one frame, then the issued command (k zero: none expected)
    task automatic issue(input logic [63:0] v, input int nb, input int w,
                         input logic [2:0] k, input logic [7:0] op, input logic [23:0] a);
        int n0;
        n0 = n_cmd;
        i_sfcf_host.frame(v, nb, w);
        chk(40'(n_cmd - n0), (k == 3'h0) ? 40'h0 : 40'h1);
        if (k != 3'h0) chk({c_kind, c_op}, {k, op});
        if (k != 3'h0 && nb > 8) chk(c_addr, a);
    endtask : issue
    // one read frame, then the last two bytes the host saw
    task automatic rd(input logic [63:0] v, input int nb, input int w, input logic [15:0] e);
        i_sfcf_host.frame(v, nb, w);
        chk(40'(i_sfcf_host.rx[15:0]), 40'(e));
    endtask : rd
    task automatic t_read;
        i_sfcf_host.set_pol(1'b1);
        rd({24'h0, 8'h03, 24'h000010, 8'h00}, 40, 1, 16'h004a);
        i_sfcf_host.set_pol(1'b0);
    endtask : t_read
    task automatic t_erase;
        issue({32'h0, 8'h20, 24'h123456}, 32, 1, K_ERASE, 8'h20, 24'h123456);
        issue({32'h0, 8'h52, 24'h3f8000}, 32, 1, K_ERASE, 8'h52, 24'h3f8000);
        i_sfcf_host.set_pol(1'b1);
        issue({32'h0, 8'hd8, 24'h010000}, 32, 1, K_ERASE, 8'hd8, 24'h010000);
        i_sfcf_host.set_pol(1'b0);
        issue({56'h0, 8'h60}, 8, 1, K_CHIP, 8'h60, 24'h0);
    endtask : t_erase
    task automatic t_mode;
        issue({56'h0, 8'h35}, 8, 1, 3'h0, 8'h0, 24'h0);
        chk(qm, 1'b1);
        issue({56'h0, 8'hc7}, 8, 4, K_CHIP, 8'hc7, 24'h0);
        issue({32'h0, 8'h20, 24'hab0000}, 32, 4, K_ERASE, 8'h20, 24'hab0000);
        rd({8'h0b, 24'h000120, 32'h0}, 64, 4, 16'h7a7b);
        issue({56'h0, 8'hf5}, 8, 4, 3'h0, 8'h0, 24'h0);
        chk(qm, 1'b0);
    endtask : t_mode
    task automatic t_reject;
        issue({31'h0, 8'h20, 24'h001000, 1'b0}, 33, 1, 3'h0, 8'h0, 24'h0);
        issue({56'h0, 8'hff}, 8, 1, 3'h0, 8'h0, 24'h0);
        @(negedge clk) busy = 1'b1;
        issue({32'h0, 8'h20, 24'h002000}, 32, 1, 3'h0, 8'h0, 24'h0);
        rd({24'h0, 8'h03, 24'h000010, 8'h00}, 40, 1, 16'h0000);
        @(negedge clk) busy = 1'b0;
    endtask : t_reject
    task automatic t_prog;
        issue({24'h0, 8'h02, 24'h000010, 8'ha5}, 40, 1, K_PROG, 8'h02, 24'h10);
        chk(c_len, 9'h001);
        @(negedge clk) pg_idx = 8'h10;
        @(negedge clk);
        chk(pg_data, 8'ha5);
    endtask : t_prog
    task automatic end_of_test;
        if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    initial begin
        #400 arst_n = 1'b1;
        #100;
        t_erase;
        t_read;
        t_mode;
        t_reject;
        t_prog;
        end_of_test;
    end
    // watchdog well beyond the frames above
    initial begin
        #60000 mismatches++;
        end_of_test;
    end
endmodule : sfcf_front_end_tb
